// File: src/crsd_pkg.sv
package crsd_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PLAT_CODE_W = 4;
    localparam int CORE_CODE_W = 2;
    localparam int RATIO_W = 5;
    localparam int CORE_X2_W = 3;
    localparam int MHZ_W = 11;

    // ------------------------------------------------------------
    // Ratio tables
    // ------------------------------------------------------------
    // Platform multiple per strap code; zero marks a reserved code.
    localparam logic [RATIO_W-1:0] PLAT_RATIO_LUT [16] = '{
        5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00,
        5'h08, 5'h09, 5'h0a, 5'h00, 5'h0c, 5'h00, 5'h00, 5'h00};
    localparam logic [RATIO_W-1:0] PLAT_RATIO_RSVD = 5'h00;
    // Core multiple of the platform clock, counted in halves.
    localparam logic [CORE_X2_W-1:0] CORE_X2_LUT [4] = '{3'h4, 3'h5, 3'h6, 3'h7};

    // ------------------------------------------------------------
    // Frequency limits and default reference frequency in MHz
    // ------------------------------------------------------------
    localparam int MEM_MIN_MHZ = 100;
    localparam int MEM_MAX_MHZ = 166;
    localparam int PLAT_MIN_MHZ = 200;
    localparam int CORE_MIN_MHZ = 400;
    localparam int REF_FREQ_MHZ_DEF = 100;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [RATIO_W-1:0] RATIO_RST = 5'h00;
    localparam logic [CORE_X2_W-1:0] CORE_X2_RST = 3'h0;
    localparam logic [MHZ_W-1:0] MHZ_RST = 11'h000;
endpackage

// File: src/crsd_ratio_if.sv
`timescale 1ns/10ps
interface crsd_ratio_if;
    import crsd_pkg::*;
    logic [PLAT_CODE_W-1:0] plat_code;
    logic [CORE_CODE_W-1:0] core_code;
    logic [RATIO_W-1:0] plat_ratio;
    logic plat_rsvd;
    logic [CORE_X2_W-1:0] core_x2;
    modport ctl (output plat_code, output core_code, input plat_ratio, input plat_rsvd,
        input core_x2);
    modport dec (input plat_code, input core_code, output plat_ratio, output plat_rsvd,
        output core_x2);
endinterface

// File: src/crsd_ratio_decode.sv
`timescale 1ns/10ps
module crsd_ratio_decode (
    crsd_ratio_if.dec rif
);
    import crsd_pkg::*;

    function automatic logic [RATIO_W-1:0] plat_ratio_of(input logic [PLAT_CODE_W-1:0] code);
        plat_ratio_of = PLAT_RATIO_LUT[code];
    endfunction

    assign rif.plat_ratio = plat_ratio_of(rif.plat_code);
    assign rif.plat_rsvd = (plat_ratio_of(rif.plat_code) == PLAT_RATIO_RSVD);
    // High strap is the first bit of the code, low strap the second.
    assign rif.core_x2 = CORE_X2_LUT[rif.core_code];
endmodule // crsd_ratio_decode

// File: src/crsd_top.sv
`timescale 1ns/10ps
module crsd_top #(
    parameter int REF_FREQ_MHZ = crsd_pkg::REF_FREQ_MHZ_DEF
) (
    input wire logic clk,
    input wire logic clk_en,
    input wire logic resetn,
    input wire logic [crsd_pkg::PLAT_CODE_W-1:0] platform_ratio_strap,
    input wire logic core_ratio_strap_hi,
    input wire logic core_ratio_strap_lo,
    input wire logic pci_width_strap,
    output logic strap_pullup_en,
    output logic memory_sync_feedback_out,
    output logic memory_sync_feedback_out_oe_n,
    output logic config_valid,
    output logic [crsd_pkg::RATIO_W-1:0] platform_ratio,
    output logic platform_ratio_reserved,
    output logic [crsd_pkg::CORE_X2_W-1:0] core_ratio_x2,
    output logic [crsd_pkg::MHZ_W-1:0] platform_freq_mhz,
    output logic [crsd_pkg::MHZ_W-1:0] mem_freq_mhz,
    output logic mem_freq_ok,
    output logic plat_freq_ok,
    output logic core_freq_ok,
    output logic pci_64bit
);
    import crsd_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Straps come from pins, so they pass two flops before capture.
    logic [PLAT_CODE_W+CORE_CODE_W:0] strap_s1_r;
    logic [PLAT_CODE_W+CORE_CODE_W:0] strap_s2_r;

    always_ff @(posedge clk) begin
        if (clk_en) begin
            strap_s1_r <= {platform_ratio_strap, core_ratio_strap_hi, core_ratio_strap_lo,
                pci_width_strap};
            strap_s2_r <= strap_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    // The capture follows the pins during reset and freezes at release, so the
    // shared local bus pins may toggle freely afterwards.
    logic [PLAT_CODE_W-1:0] plat_code_r;
    logic [CORE_CODE_W-1:0] core_code_r;
    logic pci_strap_r;

    always_ff @(posedge clk) begin
        if (clk_en && !resetn) begin
            plat_code_r <= strap_s2_r[PLAT_CODE_W+CORE_CODE_W:CORE_CODE_W+1];
            core_code_r <= strap_s2_r[CORE_CODE_W:1];
            pci_strap_r <= strap_s2_r[0];
        end
    end

    crsd_ratio_if rif ();
    assign rif.plat_code = plat_code_r;
    assign rif.core_code = core_code_r;

    crsd_ratio_decode crsd_ratio_decode_i (
        .rif(rif)
    );

    // ------------------------------------------------------------
    // Reset-time pin control
    // ------------------------------------------------------------
    logic pullup_r;
    logic valid_r;

    always_ff @(posedge clk) begin
        if (clk_en) begin
            pullup_r <= !resetn;
            valid_r <= resetn;
        end
    end
    assign strap_pullup_en = pullup_r;
    assign config_valid = valid_r;

    // The feedback pin is never released, not even in reset; it toggles at
    // half the clock rate once the configuration is valid.
    logic fb_toggle_r;

    always_ff @(posedge clk) begin
        if (clk_en) begin
            if (!resetn) begin
                fb_toggle_r <= 1'b0;
            end else if (valid_r) begin
                fb_toggle_r <= !fb_toggle_r;
            end
        end
    end
    assign memory_sync_feedback_out = fb_toggle_r;
    assign memory_sync_feedback_out_oe_n = 1'b0;

    // ------------------------------------------------------------
    // Decoded ratios and frequency checks
    // ------------------------------------------------------------
    logic [RATIO_W-1:0] plat_ratio_r;
    logic plat_rsvd_r;
    logic [CORE_X2_W-1:0] core_x2_r;
    logic [MHZ_W-1:0] plat_mhz_r;
    logic [MHZ_W-1:0] plat_mhz_nxt;
    logic [MHZ_W-1:0] mem_mhz_r;
    logic [MHZ_W-1:0] mem_mhz_nxt;
    logic [MHZ_W+2:0] core_mhz_nxt;
    logic mem_ok_r;
    logic plat_ok_r;
    logic core_ok_r;
    logic pci64_r;

    always_comb begin
        plat_mhz_nxt = MHZ_W'(REF_FREQ_MHZ * int'(rif.plat_ratio));
        mem_mhz_nxt = plat_mhz_nxt >> 1;
        core_mhz_nxt = (MHZ_W+3)'((int'(plat_mhz_nxt) * int'(rif.core_x2)) >> 1);
    end

    // Outputs settle one cycle after release and then never move until reset.
    always_ff @(posedge clk) begin
        if (clk_en) begin
            if (!resetn) begin
                plat_ratio_r <= RATIO_RST;
                plat_rsvd_r <= 1'b0;
                core_x2_r <= CORE_X2_RST;
                plat_mhz_r <= MHZ_RST;
                mem_mhz_r <= MHZ_RST;
                mem_ok_r <= 1'b0;
                plat_ok_r <= 1'b0;
                core_ok_r <= 1'b0;
                pci64_r <= 1'b0;
            end else if (!valid_r) begin
                plat_ratio_r <= rif.plat_ratio;
                plat_rsvd_r <= rif.plat_rsvd;
                core_x2_r <= rif.core_x2;
                plat_mhz_r <= plat_mhz_nxt;
                mem_mhz_r <= mem_mhz_nxt;
                mem_ok_r <= (int'(mem_mhz_nxt) >= MEM_MIN_MHZ)
                    && (int'(mem_mhz_nxt) <= MEM_MAX_MHZ);
                plat_ok_r <= int'(plat_mhz_nxt) >= PLAT_MIN_MHZ;
                core_ok_r <= int'(core_mhz_nxt) >= CORE_MIN_MHZ;
                // A low strap through reset selects the wide bus.
                pci64_r <= !pci_strap_r;
            end
        end
    end

    assign platform_ratio = plat_ratio_r;
    assign platform_ratio_reserved = plat_rsvd_r;
    assign core_ratio_x2 = core_x2_r;
    assign platform_freq_mhz = plat_mhz_r;
    assign mem_freq_mhz = mem_mhz_r;
    assign mem_freq_ok = mem_ok_r;
    assign plat_freq_ok = plat_ok_r;
    assign core_freq_ok = core_ok_r;
    assign pci_64bit = pci64_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ratio_hold: assert property (@(posedge clk) disable iff (!resetn)
        valid_r && $past(valid_r) |-> $stable(plat_ratio_r) && $stable(core_x2_r))
        else $error("ratio changed after release");

    chk_plat_twelve: assert property (@(posedge clk) disable iff (!resetn)
        valid_r && plat_code_r == 4'hc |-> plat_ratio_r == 5'h0c)
        else $error("code 1100 not decoded as 12");

    chk_rsvd_flag: assert property (@(posedge clk) disable iff (!resetn)
        valid_r |-> plat_rsvd_r == (plat_ratio_r == 5'h00))
        else $error("reserved flag disagrees with ratio");

    chk_core_decode: assert property (@(posedge clk) disable iff (!resetn)
        valid_r |-> core_x2_r == {1'b1, core_code_r})
        else $error("core ratio decode wrong");

    chk_strap_capture: assert property (@(posedge clk) disable iff (!resetn)
        $rose(valid_r) && $past(clk_en, 2) |->
        plat_code_r == $past(strap_s2_r[PLAT_CODE_W+CORE_CODE_W:CORE_CODE_W+1], 2))
        else $error("platform strap not captured at release");

    chk_pullup_off: assert property (@(posedge clk) disable iff (!resetn)
        valid_r |-> !pullup_r)
        else $error("pull-up active outside reset");

    chk_sync_driven: assert property (@(posedge clk) disable iff (!resetn)
        $past(!resetn) |-> !memory_sync_feedback_out_oe_n && !fb_toggle_r)
        else $error("feedback pin not driven through reset");

    chk_mem_range: assert property (@(posedge clk) disable iff (!resetn)
        valid_r |-> mem_ok_r == (mem_mhz_r >= 11'h064 && mem_mhz_r <= 11'h0a6)
            && mem_mhz_r == (plat_mhz_r >> 1))
        else $error("memory clock range flag wrong");

    chk_mem_toggle: assert property (@(posedge clk) disable iff (!resetn)
        valid_r && clk_en ##1 clk_en |-> fb_toggle_r != $past(fb_toggle_r))
        else $error("feedback clock not at half rate");

    chk_plat_sixteen: assert property (@(posedge clk) disable iff (!resetn)
        valid_r && plat_code_r == 4'h0 |-> plat_ratio_r == 5'h10)
        else $error("code 0000 not decoded as 16");

    chk_pci_capture: assert property (@(posedge clk) disable iff (!resetn)
        $rose(valid_r) && $past(clk_en, 2) |->
        pci64_r == !$past(strap_s2_r[0], 2))
        else $error("bus width strap not captured at release");

    chk_flag_hold: assert property (@(posedge clk) disable iff (!resetn)
        valid_r && $past(valid_r) |-> $stable(pci64_r) && $stable(plat_mhz_r))
        else $error("latched configuration changed after release");
endmodule // crsd_top

// File: tb/crsd_strap_model.sv
`timescale 1ns/10ps
// Board straps and reset logic: codes are held through reset, then the pins are shared.
module crsd_strap_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic strap_pullup_en,
    input wire logic [3:0] plat_code,
    input wire logic [1:0] core_code,
    input wire logic pci_low,
    output logic [3:0] platform_ratio_strap,
    output logic core_ratio_strap_hi,
    output logic core_ratio_strap_lo,
    output logic pci_width_strap
);
    // After release the pins carry other traffic, so they change every cycle.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            platform_ratio_strap <= plat_code;
            {core_ratio_strap_hi, core_ratio_strap_lo} <= core_code;
            pci_width_strap <= pci_low ? 1'b0 : strap_pullup_en;
        end else begin
            platform_ratio_strap <= ~platform_ratio_strap;
            {core_ratio_strap_hi, core_ratio_strap_lo} <=
                ~{core_ratio_strap_hi, core_ratio_strap_lo};
            pci_width_strap <= ~pci_width_strap;
        end
    end
endmodule // crsd_strap_model

// File: tb/tb_clock_ratio_strap_decode.sv
`timescale 1ns/10ps
module tb_clock_ratio_strap_decode;
    import crsd_pkg::*;
    typedef struct packed {logic [3:0] pc; logic [1:0] cc; logic [4:0] ratio;} crsd_row_t;
    localparam int REF = 100;
    localparam crsd_row_t ROWS [16] = '{
        '{4'h0, 2'h0, 5'h10}, '{4'h1, 2'h1, 5'h00}, '{4'h2, 2'h2, 5'h02}, '{4'h3, 2'h3, 5'h03},
        '{4'h4, 2'h0, 5'h04}, '{4'h5, 2'h1, 5'h05}, '{4'h6, 2'h2, 5'h06}, '{4'h7, 2'h3, 5'h00},
        '{4'h8, 2'h0, 5'h08}, '{4'h9, 2'h1, 5'h09}, '{4'ha, 2'h2, 5'h0a}, '{4'hb, 2'h3, 5'h00},
        '{4'hc, 2'h0, 5'h0c}, '{4'hd, 2'h1, 5'h00}, '{4'he, 2'h2, 5'h00}, '{4'hf, 2'h3, 5'h00}};
    logic clk = 1'b0;
    logic clk_en = 1'b1;
    logic resetn = 1'b0;
    logic [3:0] pc = 4'h0;
    logic [1:0] cc = 2'h0;
    logic pl = 1'b0;
    logic [3:0] ps;
    logic sh, sl, pw, pu, fb, oe_n, cv, rsvd, mok, pok, cok, p64;
    logic [RATIO_W-1:0] ratio;
    logic [CORE_X2_W-1:0] x2;
    logic [MHZ_W-1:0] pf, mf;
    int n_errors = 0;
    int n_compared = 0;
    int f;
    logic prev;

    initial forever #5 clk = ~clk;

    crsd_strap_model crsd_strap_model_i (.clk(clk), .resetn(resetn), .strap_pullup_en(pu),
        .plat_code(pc), .core_code(cc), .pci_low(pl), .platform_ratio_strap(ps),
        .core_ratio_strap_hi(sh), .core_ratio_strap_lo(sl), .pci_width_strap(pw));
    crsd_top #(.REF_FREQ_MHZ(REF)) crsd_top_i (.clk(clk), .clk_en(clk_en), .resetn(resetn),
        .platform_ratio_strap(ps), .core_ratio_strap_hi(sh), .core_ratio_strap_lo(sl),
        .pci_width_strap(pw), .strap_pullup_en(pu), .memory_sync_feedback_out(fb),
        .memory_sync_feedback_out_oe_n(oe_n), .config_valid(cv), .platform_ratio(ratio),
        .platform_ratio_reserved(rsvd), .core_ratio_x2(x2), .platform_freq_mhz(pf),
        .mem_freq_mhz(mf), .mem_freq_ok(mok), .plat_freq_ok(pok), .core_freq_ok(cok),
        .pci_64bit(p64));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("compared=%0d errors=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        close_out();
    end

    initial begin
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) resetn <= 1'b0;
            pc <= ROWS[i].pc;
            cc <= ROWS[i].cc;
            pl <= i[0];
            repeat (12) @(posedge clk);
            #1 chk(16'(pu), 16'h1);
            chk(16'(cv), 16'h0);
            chk(16'(oe_n), 16'h0);
            chk(16'(fb), 16'h0);
            @(posedge clk) resetn <= 1'b1;
            @(posedge clk);
            #1 f = REF * int'(ROWS[i].ratio);
            chk(16'(ratio), 16'(ROWS[i].ratio));
            chk(16'(rsvd), 16'(ROWS[i].ratio == 5'h00));
            chk(16'(x2), 16'(ROWS[i].cc) + 16'h4);
            chk(16'(pf), 16'(f));
            chk(16'(mf), 16'(f / 2));
            chk(16'(mok), 16'(f / 2 >= 100 && f / 2 <= 166));
            chk(16'(pok), 16'(f >= 200));
            chk(16'(cok), 16'(f * (int'(ROWS[i].cc) + 4) / 2 >= 400));
            chk(16'(p64), 16'(i[0]));
            chk(16'(pu), 16'h0);
            chk(16'(cv), 16'h1);
            prev = fb;
            repeat (3) @(posedge clk);
            #1 chk(16'(fb), 16'(!prev));
            chk(16'(ratio), 16'(ROWS[i].ratio));
            chk(16'(x2), 16'(ROWS[i].cc) + 16'h4);
            chk(16'(p64), 16'(i[0]));
        end
        // A disabled clock freezes the outputs and holds off a reset request.
        @(posedge clk) clk_en <= 1'b0;
        resetn <= 1'b0;
        @(posedge clk);
        #1 prev = fb;
        repeat (2) @(posedge clk);
        #1 chk(16'(fb), 16'(prev));
        chk(16'(cv), 16'h1);
        close_out();
    end
endmodule // tb_clock_ratio_strap_decode
